// ### pospd_pkg.sv
// constants and carrier types for the pulse output and speed command setup block
// assumes a single 100 MHz system clock and a plain register port
package pospd_pkg;
  localparam int unsigned CLK_MHZ = 100;

  localparam logic [7:0] ADDR_PHASE    = 8'h00;
  localparam logic [7:0] ADDR_GAIN     = 8'h04;
  localparam logic [7:0] ADDR_POLARITY = 8'h08;
  localparam logic [7:0] ADDR_CLAMP    = 8'h0c;
  localparam logic [7:0] ADDR_CONTROL  = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;

  localparam logic [1:0]  PHASE_RESET    = 2'h0;
  localparam logic [1:0]  PHASE_MAX      = 2'h3;
  localparam int          PHASE_INV_BIT  = 0;
  localparam int          PHASE_SRC_BIT  = 1;
  localparam logic [10:0] GAIN_MIN       = 11'h00a;
  localparam logic [10:0] GAIN_MAX       = 11'h7d0;
  localparam logic [10:0] GAIN_RESET     = 11'h1f4;
  localparam logic        POLARITY_RESET = 1'h1;
  localparam logic [1:0]  CLAMP_RESET    = 2'h0;
  localparam logic [1:0]  CLAMP_NO_POL   = 2'h2;
  localparam int          CTRL_FULL_BIT  = 0;
  localparam int          VOLT_FRAC_BITS = 10;
  localparam int          SYNC_WIDTH     = 5;

  typedef struct packed {
    logic a;
    logic b;
  } pospd_quad_t;

  typedef struct packed {
    pospd_quad_t encoder;
    pospd_quad_t scale;
    logic        power_on;
  } pospd_pins_t;
endpackage

// ### pospd_sync.sv
// three-stage input synchroniser with agreement filter
// assumes inputs are asynchronous to clk_sys; output changes once stages two and three agree
`timescale 1ns/1ps
module pospd_sync
  import pospd_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input  wire logic             clk_sys,  // system clock
  input  wire logic             rst_n,    // synchronised reset, active low
  input  wire logic [WIDTH-1:0] async_in, // pin levels
  output logic      [WIDTH-1:0] sync_out  // filtered level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_out;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_comb
      begin
        next_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      stage2   <= stage1;
      stage3   <= stage2;
      sync_out <= next_out;
    end
  end
endmodule

// ### pospd_top.sv
// Operation
// - phase setting 0-3: bit0 inverts B, bit1 picks scale
// - scale source only used in full-closed control
// - phase setting written pending, applied at power-on
// - gain 10..2000 scales input voltage linearly, default 500
// - polarity 0..1, default 1, inverts command sign
// - polarity 0 positive is CCW, 1 is CW
// - polarity ignored when zero clamp setting is 2
//
// pulse output source/phase and speed command scaling for a servo drive
// assumes encoder/scale/power pins are asynchronous, speed sample is on clk_sys
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module pospd_top
  import pospd_pkg::*;
(
  input  wire logic               clk_sys,          // 100 MHz system clock
  input  wire logic               reset_n,          // async reset, active low
  input  wire logic [7:0]         addr,             // register byte address
  input  wire logic [31:0]        wr_data,          // write data
  input  wire logic               wr_en,            // write strobe
  input  wire logic               rd_en,            // read strobe
  output logic      [31:0]        rd_data,          // read data, cycle after rd_en
  input  wire pospd_quad_t        encoder_pulse,    // encoder A/B pins
  input  wire pospd_quad_t        scale_pulse,      // external scale A/B pins
  input  wire logic               control_power_on, // control power present pin
  input  wire logic signed [13:0] speed_command_input, // volts, 10 fraction bits
  output pospd_quad_t             pulse_out,        // pulse_out_phase_a / _b
  output logic signed [16:0]      speed_demand      // r/min, positive is CCW
);
  logic        rst_meta;
  logic        rst_n;
  pospd_pins_t pins_sync;
  logic        power_prev;
  logic [1:0]  pulse_out_phase_source_setting;
  logic [1:0]  phase_active;
  logic [10:0] speed_command_gain_setting;
  logic        speed_command_polarity_setting;
  logic [1:0]  zero_clamp_config_setting;
  logic        full_closed;
  logic [1:0]  next_phase_pending;
  logic [1:0]  next_phase_active;
  logic [10:0] next_gain;
  logic        next_polarity;
  logic [1:0]  next_clamp;
  logic        next_full_closed;
  logic [31:0] next_rd_data;
  pospd_quad_t next_pulse;
  pospd_quad_t src_pulse;
  logic signed [25:0] product;
  logic signed [15:0] scaled;
  logic               invert;
  logic signed [16:0] next_demand;

  // reset release through two flops so every flop leaves reset on the same edge
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  pospd_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in ({encoder_pulse, scale_pulse, control_power_on}),
    .sync_out (pins_sync)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // settings and register read path
  always_comb
  begin
    next_phase_pending = pulse_out_phase_source_setting;
    next_gain          = speed_command_gain_setting;
    next_polarity      = speed_command_polarity_setting;
    next_clamp         = zero_clamp_config_setting;
    next_full_closed   = full_closed;
    next_phase_active  = phase_active;
    next_rd_data       = 32'h0000_0000;
    // out-of-range values are dropped so the settings never leave their ranges
    if (wr_en)
    begin
      if (hit(addr, ADDR_PHASE) && wr_data <= {30'h0, PHASE_MAX})
        next_phase_pending = wr_data[1:0];
      if (hit(addr, ADDR_GAIN) && wr_data >= {21'h0, GAIN_MIN}
          && wr_data <= {21'h0, GAIN_MAX})
        next_gain = wr_data[10:0];
      if (hit(addr, ADDR_POLARITY) && wr_data[31:1] == 31'h0)
        next_polarity = wr_data[0];
      if (hit(addr, ADDR_CLAMP) && wr_data[31:2] == 30'h0)
        next_clamp = wr_data[1:0];
      if (hit(addr, ADDR_CONTROL))
        next_full_closed = wr_data[CTRL_FULL_BIT];
    end
    // the pending value only goes live at a rising edge of control power
    if (pins_sync.power_on && !power_prev)
      next_phase_active = pulse_out_phase_source_setting;
    if (rd_en)
    begin
      unique case (addr)
        ADDR_PHASE:    next_rd_data = {30'h0, pulse_out_phase_source_setting};
        ADDR_GAIN:     next_rd_data = {21'h0, speed_command_gain_setting};
        ADDR_POLARITY: next_rd_data = {31'h0, speed_command_polarity_setting};
        ADDR_CLAMP:    next_rd_data = {30'h0, zero_clamp_config_setting};
        ADDR_CONTROL:  next_rd_data = {31'h0, full_closed};
        ADDR_STATUS:   next_rd_data = {29'h0, pins_sync.power_on, phase_active};
        default:       next_rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulse_out_phase_source_setting <= PHASE_RESET;
      phase_active                   <= PHASE_RESET;
      speed_command_gain_setting     <= GAIN_RESET;
      speed_command_polarity_setting <= POLARITY_RESET;
      zero_clamp_config_setting      <= CLAMP_RESET;
      full_closed                    <= 1'b0;
      power_prev                     <= 1'b0;
      rd_data                        <= 32'h0000_0000;
    end
    else
    begin
      pulse_out_phase_source_setting <= next_phase_pending;
      phase_active                   <= next_phase_active;
      speed_command_gain_setting     <= next_gain;
      speed_command_polarity_setting <= next_polarity;
      zero_clamp_config_setting      <= next_clamp;
      full_closed                    <= next_full_closed;
      power_prev                     <= pins_sync.power_on;
      rd_data                        <= next_rd_data;
    end
  end

  // pulse output path
  always_comb
  begin
    // outside full-closed control the scale choice falls back to the encoder
    src_pulse = (phase_active[PHASE_SRC_BIT] && full_closed) ? pins_sync.scale
                                                             : pins_sync.encoder;
    next_pulse.a = src_pulse.a;
    next_pulse.b = src_pulse.b ^ phase_active[PHASE_INV_BIT];
  end

  // speed command path: volts times (r/min)/V, one cycle of latency
  always_comb
  begin
    product = speed_command_input * $signed({1'b0, speed_command_gain_setting});
    scaled  = product[25:VOLT_FRAC_BITS];
    invert  = speed_command_polarity_setting
              && (zero_clamp_config_setting != CLAMP_NO_POL);
    // positive demand means CCW, so polarity 1 turns a positive command CW
    next_demand = invert ? -$signed({scaled[15], scaled})
                         : $signed({scaled[15], scaled});
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulse_out    <= '0;
      speed_demand <= '0;
    end
    else
    begin
      pulse_out    <= next_pulse;
      speed_demand <= next_demand;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  phase_apply_a: assert property (
    $past(pins_sync.power_on) && !$past(power_prev)
    |-> phase_active == $past(pulse_out_phase_source_setting))
    else $error("phase setting not applied at power-on");

  pending_hold_a: assert property (
    !($past(pins_sync.power_on) && !$past(power_prev)) |-> $stable(phase_active))
    else $error("phase setting changed without power-on");

  // checked against the synchronised pins, not the internal mux, so a broken mux shows up
  b_invert_a: assert property (
    !full_closed
    |=> pulse_out.b == ($past(pins_sync.encoder.b) ^ $past(phase_active[PHASE_INV_BIT])))
    else $error("B output not complemented per setting");

  phase_a_pass_a: assert property (
    !phase_active[PHASE_SRC_BIT] |=> pulse_out.a == $past(pins_sync.encoder.a))
    else $error("A output not taken from encoder");

  scale_pick_a: assert property (
    full_closed && phase_active[PHASE_SRC_BIT]
    |=> pulse_out.a == $past(pins_sync.scale.a)
        && pulse_out.b == ($past(pins_sync.scale.b) ^ $past(phase_active[PHASE_INV_BIT])))
    else $error("scale not used in full-closed control");

  source_gate_a: assert property (
    !full_closed |=> pulse_out.a == $past(pins_sync.encoder.a))
    else $error("scale used outside full-closed control");

  gain_range_a: assert property (
    speed_command_gain_setting >= GAIN_MIN && speed_command_gain_setting <= GAIN_MAX)
    else $error("gain setting out of range");

  polarity_a: assert property (
    speed_command_input > 0 && speed_command_input * 1 >= 14'sh0400
    && !speed_command_polarity_setting |=> speed_demand > 0)
    else $error("polarity 0 positive command not CCW");

  clamp_ignore_a: assert property (
    zero_clamp_config_setting == CLAMP_NO_POL && speed_command_input >= 14'sh0400
    |=> speed_demand > 0)
    else $error("polarity applied while zero clamp is 2");

  invert_c: cover property (speed_command_polarity_setting && speed_command_input > 0);
  power_c:  cover property (pins_sync.power_on && !power_prev);
  scale_c:  cover property (full_closed && phase_active[PHASE_SRC_BIT]);
endmodule

// ### pospd_host_model.sv
// host-side stand-in: quadrature pins of encoder and scale, control power pin
// assumes the bench steps it on clk_sys; pins are plain levels
`timescale 1ns/1ps
module pospd_host_model
  import pospd_pkg::*;
(
  input  wire logic   clk_sys,          // system clock
  input  wire logic   step,             // advance position one count
  input  wire logic   power_req,        // requested control power level
  output pospd_quad_t encoder_pulse,    // encoder a/b
  output pospd_quad_t scale_pulse,      // scale a/b
  output logic        control_power_on  // control power present
);
  logic [1:0] pos = 2'h0;
  logic [1:0] spos;
  always @(posedge clk_sys)
    pos <= pos + {1'b0, step};
  // scale sits one count ahead so the two sources never look alike
  assign spos = pos + 2'h1;
  assign encoder_pulse = '{a: pos[1], b: pos[1] ^ pos[0]};
  assign scale_pulse = '{a: spos[1], b: spos[1] ^ spos[0]};
  assign control_power_on = power_req;
endmodule

// ### pospd_top_tb_top.sv
// self-checking bench: register port, pulse source/phase and speed scaling
// assumes pospd_top and pospd_host_model; one 100 MHz clock
`timescale 1ns/1ps
module pospd_top_tb_top
  import pospd_pkg::*;
;
  logic               clk_sys = 1'b0;
  logic               reset_n = 1'b0;
  logic [7:0]         addr = 8'h00;
  logic [31:0]        wr_data = 32'h0;
  logic               wr_en = 1'b0;
  logic               rd_en = 1'b0;
  logic [31:0]        rd_data;
  logic               step = 1'b0;
  logic               power_req = 1'b1;
  logic signed [13:0] speed_command_input = 14'h0;
  pospd_quad_t        encoder_pulse, scale_pulse, pulse_out, src;
  logic               control_power_on;
  logic signed [16:0] speed_demand;
  integer             fail_count = 0, num_checks = 0, e, seed = 32'haf94333b;
  logic [1:0]         ph_pend = PHASE_RESET, ph_act = PHASE_RESET, clamp = CLAMP_RESET;
  logic [10:0]        gain = GAIN_RESET;
  logic               pol = POLARITY_RESET, full = 1'b0;

  always #5 clk_sys = ~clk_sys;

  pospd_host_model i_host (.clk_sys(clk_sys), .step(step), .power_req(power_req),
    .encoder_pulse(encoder_pulse), .scale_pulse(scale_pulse),
    .control_power_on(control_power_on));
  pospd_top i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .encoder_pulse(encoder_pulse),
    .scale_pulse(scale_pulse), .control_power_on(control_power_on),
    .speed_command_input(speed_command_input), .pulse_out(pulse_out),
    .speed_demand(speed_demand));

  task automatic finish_test;
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // model follows every write; out-of-range values are dropped like the design does
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    case (a)
      ADDR_PHASE:    if (v <= PHASE_MAX) ph_pend = v[1:0];
      ADDR_GAIN:     if (v >= GAIN_MIN && v <= GAIN_MAX) gain = v[10:0];
      ADDR_POLARITY: if (v <= 1) pol = v[0];
      ADDR_CLAMP:    if (v <= 3) clamp = v[1:0];
      ADDR_CONTROL:  full = v[0];
      default: ;
    endcase
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask

  // pin changes reach pulse_out after five edges, power-on phase changes after six; eight leaves margin
  task automatic chk_pulse;
    repeat (8) @(posedge clk_sys);
    #1 src = (ph_act[PHASE_SRC_BIT] && full) ? scale_pulse : encoder_pulse;
    chk({30'h0, pulse_out}, {30'h0, src.a, src.b ^ ph_act[PHASE_INV_BIT]});
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdchk(ADDR_GAIN, 32'(GAIN_RESET));
    rdchk(ADDR_POLARITY, 32'(POLARITY_RESET));
    rdchk(ADDR_PHASE, 32'h0);
    rdchk(8'h18, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_GAIN, (i[0] ? 32'd2001 : 32'd9) - 32'(i[1]));
      rdchk(ADDR_GAIN, 32'(gain));
    end
    wr(ADDR_PHASE, 32'h4);
    wr(ADDR_POLARITY, 32'h2);
    rdchk(ADDR_PHASE, 32'(ph_pend));
    rdchk(ADDR_POLARITY, 32'(pol));
    for (int f = 0; f < 2; f++)
      for (int p = 0; p < 4; p++)
      begin
        wr(ADDR_CONTROL, 32'(f));
        rdchk(ADDR_CONTROL, 32'(full));
        wr(ADDR_PHASE, 32'(p));
        chk_pulse();
        rdchk(ADDR_STATUS, {29'h0, 1'b1, ph_act});
        @(posedge clk_sys);
        power_req <= 1'b0;
        repeat (8) @(posedge clk_sys);
        power_req <= 1'b1;
        ph_act = ph_pend;
        for (int k = 0; k < 4; k++)
        begin
          chk_pulse();
          step <= 1'b1;
          @(posedge clk_sys);
          step <= 1'b0;
        end
      end
    for (int i = 0; i < 32; i++)
    begin
      wr(ADDR_GAIN, i == 0 ? 32'd500 : 32'd10 + ($unsigned($random(seed)) % 1991));
      wr(ADDR_POLARITY, i == 0 ? 32'h1 : 32'($random(seed) & 1));
      wr(ADDR_CLAMP, 32'(i % 4));
      rdchk(ADDR_CLAMP, 32'(clamp));
      @(posedge clk_sys);
      // 6 V, then full negative scale
      speed_command_input <= (i == 0) ? 14'sh1800 : (i == 1) ? 14'sh2000 : 14'($random(seed));
      @(posedge clk_sys);
      @(posedge clk_sys);
      #1 e = (int'(speed_command_input) * int'(gain)) >>> VOLT_FRAC_BITS;
      if (pol && clamp != CLAMP_NO_POL)
        e = -e;
      chk({15'h0, speed_demand}, {15'h0, e[16:0]});
    end
    finish_test();
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    finish_test();
  end
endmodule
